// file: logic/dpi_interlock.sv
// Interlock and stall control of a four-stage fetch/decode/read/execute
// pipeline, covering addressing-register delays and memory bandwidth.
// Assumes the stage descriptors and port ready levels come from logic on
// the same clock; only the external flag pin is asynchronous.
//
// How it works
// - Execute reading an address register holds the next decode one cycle.
// - Decrement_and_branch loop counter gets the same read and write delays.
// - An internal RAM or ROM block takes two accesses a cycle at most.
// - An external port takes one access a cycle; others wait.
// - Two data accesses to a fetch's block make the fetch wait.
// - A data access starting on a port delays a fetch there.
// - No fetch starts on a bus busy with a multicycle access.
// - A started DMA access finishes; a conflicting fetch waits for it.
// - Fetch crossing either special boundary is a fresh external fetch.
// - Cached fetch after a delayed branch still meets the port wait.
// - Slow fetch keeps fetch busy, one decode bubble per extra cycle.
// - Bank crossing on the primary port adds two wait states.
// - Store then dual read: only execute advances, reads wait a cycle.
// - Two parallel stores delay the next instruction's read a cycle.
// - Interlocked load with flag one high stalls until acknowledged.
// - A data access to a busy primary or expansion bus holds every stage.
// - Priority runs execute, read, decode, fetch, DMA; lower waits.
// - Index, block size and page pointer reads cause no delay.
`timescale 1ns/1ps

module dpi_interlock
	import dpi_pkg::*;
(
	input  wire logic              CORE_CLK_I,
	input  wire logic              RST_N_I,
	input  wire logic              EXT_FLAG_ONE_I,
	input  wire dpi_exe_t          EXE_I,
	input  wire dpi_rd_t           RD_I,
	input  wire dpi_dec_t          DEC_I,
	input  wire dpi_fetch_t        FETCH_I,
	input  wire dpi_dma_t          DMA_I,
	input  wire logic              PRI_RDY_I,
	input  wire logic              EXP_RDY_I,
	input  wire logic [ADDR_W-1:0] PRI_BANK_MASK_I,
	output dpi_stage_t             STALL_O,
	output dpi_bubble_t            BUBBLE_O,
	output logic                   FETCH_START_O,
	output logic                   FETCH_DONE_O,
	output logic                   DMA_GRANT_O,
	output dpi_conf_t              CONFLICT_O
);

	// -------------------------------------------------------------
	// Reset release
	// -------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// -------------------------------------------------------------
	// External flag one synchroniser
	// -------------------------------------------------------------
	logic flag_s1_reg;
	logic flag_s2_reg;
	logic flag_s3_reg;
	logic flag_reg;

	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			flag_s1_reg <= 1'b0;
			flag_s2_reg <= 1'b0;
			flag_s3_reg <= 1'b0;
			flag_reg    <= 1'b0;
		end else begin
			flag_s1_reg <= EXT_FLAG_ONE_I;
			flag_s2_reg <= flag_s1_reg;
			flag_s3_reg <= flag_s2_reg;
			if (flag_s2_reg == flag_s3_reg) begin
				flag_reg <= flag_s3_reg;
			end
		end
	end

	// -------------------------------------------------------------
	// Per-space access counts
	// -------------------------------------------------------------
	logic [2:0]  st_cnt   [N_SPACE];
	logic [2:0]  rd_cnt   [N_SPACE];
	logic [2:0]  done_cnt [N_SPACE];
	logic        exec_hold;
	logic        rd_hold;
	logic [N_SPACE-1:0] int_over;
	logic [N_SPACE-1:0] ext_clash;

	genvar gi;
	for (gi = 0; gi < N_SPACE; gi++) begin : g_space
		localparam dpi_space_t SPACE_ID = dpi_space_t'(3'(gi));
		assign st_cnt[gi] = {2'b00, EXE_I.valid && EXE_I.st0 == SPACE_ID}
			+ {2'b00, EXE_I.valid && EXE_I.st1 == SPACE_ID};
		assign rd_cnt[gi] = {2'b00, RD_I.valid && RD_I.rd0 == SPACE_ID}
			+ {2'b00, RD_I.valid && RD_I.rd1 == SPACE_ID};
		// Work the execute and read stages actually do this cycle.
		assign done_cnt[gi] = (exec_hold ? 3'h0 : st_cnt[gi])
			+ (rd_hold ? 3'h0 : rd_cnt[gi]);
		if (gi == 0) begin : g_none
			assign int_over[gi]  = 1'b0;
			assign ext_clash[gi] = 1'b0;
		end else if (gi < 4) begin : g_int
			assign int_over[gi]  = st_cnt[gi] + rd_cnt[gi] > INT_LIMIT;
			assign ext_clash[gi] = 1'b0;
		end else begin : g_ext
			assign int_over[gi]  = 1'b0;
			// Two reads of one instruction are serialised by the port.
			assign ext_clash[gi] = st_cnt[gi] != 3'h0
				&& st_cnt[gi] + rd_cnt[gi] > EXT_LIMIT;
		end
	end

	// -------------------------------------------------------------
	// External port ownership
	// -------------------------------------------------------------
	dpi_fstate_t fs_reg;
	logic        fport_reg;
	logic [1:0]  cpu_busy_reg;
	logic [1:0]  dma_busy_reg;
	logic [1:0]  port_busy;
	logic [1:0]  port_rdy;
	logic [1:0]  dma_start;

	assign port_rdy = {EXP_RDY_I, PRI_RDY_I};

	for (gi = 0; gi < 2; gi++) begin : g_port
		assign port_busy[gi] = cpu_busy_reg[gi] || dma_busy_reg[gi]
			|| (fs_reg != FS_IDLE && fport_reg == 1'(gi));

		always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
			if (!rst_n) begin
				cpu_busy_reg[gi] <= 1'b0;
				dma_busy_reg[gi] <= 1'b0;
			end else begin
				if (cpu_busy_reg[gi]) begin
					cpu_busy_reg[gi] <= !port_rdy[gi];
				end else begin
					cpu_busy_reg[gi] <= done_cnt[gi+4] != 3'h0
						&& !port_rdy[gi];
				end
				// A DMA access once begun is never aborted.
				if (dma_busy_reg[gi]) begin
					dma_busy_reg[gi] <= !port_rdy[gi];
				end else begin
					dma_busy_reg[gi] <= dma_start[gi] && !port_rdy[gi];
				end
			end
		end
	end

	// -------------------------------------------------------------
	// Execute and read stage holds
	// -------------------------------------------------------------
	logic       ilock_hold;
	logic       hold_all;
	logic       rd_defer;
	logic [2:0] tot_st;
	logic [2:0] tot_rd;

	assign ilock_hold = EXE_I.valid && EXE_I.ilock_load && flag_reg;
	assign hold_all = (port_busy[0] && (st_cnt[4] != 3'h0
			|| rd_cnt[4] != 3'h0))
		|| (port_busy[1] && (st_cnt[5] != 3'h0
			|| rd_cnt[5] != 3'h0));
	assign exec_hold = hold_all || ilock_hold;

	assign tot_st = {2'b00, EXE_I.valid && EXE_I.st0 != MEM_NONE}
		+ {2'b00, EXE_I.valid && EXE_I.st1 != MEM_NONE};
	assign tot_rd = {2'b00, RD_I.valid && RD_I.rd0 != MEM_NONE}
		+ {2'b00, RD_I.valid && RD_I.rd1 != MEM_NONE};

	// Store plus dual read, or dual store plus any read, needs three data
	// slots; the reads step aside while execute runs on.
	assign rd_defer = tot_st != 3'h0 && tot_rd != 3'h0
		&& (tot_st + tot_rd > DATA_LIMIT
		|| int_over != '0
		|| ext_clash != '0);
	assign rd_hold = exec_hold || rd_defer;

	// -------------------------------------------------------------
	// Register conflicts at decode
	// -------------------------------------------------------------
	function automatic logic [2:0] read_grp(input dpi_reg_t r);
		logic [2:0] g;
		g = GRP_NONE;
		unique case (r)
			RC_AUX:  g = GRP_AUX;
			RC_STK:  g = GRP_STK;
			RC_NONE, RC_IDX0, RC_IDX1, RC_BLK, RC_DPP, RC_OTHER:
				g = GRP_NONE;
		endcase
		return g;
	endfunction : read_grp

	logic [2:0] dec_grp;
	logic [2:0] exe_rgrp;
	logic [2:0] wr_grp;
	logic       reg_haz;
	logic       dec_hold;

	assign dec_grp  = DEC_I.use_grp
		| (DEC_I.loop_ctr ? GRP_AUX : GRP_NONE);
	assign exe_rgrp = EXE_I.valid
		? (read_grp(EXE_I.src_a) | read_grp(EXE_I.src_b)) : GRP_NONE;
	assign wr_grp = (RD_I.valid ? RD_I.wr_grp : GRP_NONE)
		| (EXE_I.valid ? EXE_I.wr_grp : GRP_NONE);
	// A read in execute costs one cycle; a write costs until it retires.
	assign reg_haz = DEC_I.valid
		&& ((dec_grp & exe_rgrp) != GRP_NONE
		|| (dec_grp & wr_grp) != GRP_NONE);
	assign dec_hold = rd_hold || reg_haz;

	// -------------------------------------------------------------
	// Program fetch start
	// -------------------------------------------------------------
	logic [ADDR_W-1:0] last_addr_reg;
	logic              last_valid_reg;
	logic [ADDR_W-1:0] pri_addr_reg;
	logic              pri_valid_reg;
	logic              held_reg;
	logic              fetch_ext;
	logic              fetch_port;
	logic              bnd_cross;
	logic              bank_cross;
	logic              port_need;
	logic              int_need;
	logic              pwait;
	logic              fetch_go;
	logic              fetch_done;
	logic              deliver;

	assign fetch_ext  = FETCH_I.space == MEM_PRI || FETCH_I.space == MEM_EXP;
	assign fetch_port = FETCH_I.space == MEM_EXP;
	assign bnd_cross  = last_valid_reg
		&& ((last_addr_reg == BND_A_LAST && FETCH_I.addr == BND_A_FIRST)
		|| (last_addr_reg == BND_B_LAST && FETCH_I.addr == BND_B_FIRST));
	assign bank_cross = !fetch_port && pri_valid_reg
		&& ((FETCH_I.addr ^ pri_addr_reg) & PRI_BANK_MASK_I) != '0;
	assign port_need = fetch_ext && (!FETCH_I.cache_hit
		|| bnd_cross
		|| FETCH_I.after_dly_branch);
	assign int_need = !fetch_ext && FETCH_I.space != MEM_NONE
		&& !FETCH_I.cache_hit;

	assign pwait = FETCH_I.req && fs_reg == FS_IDLE && !held_reg
		&& ((int_need && done_cnt[FETCH_I.space] >= INT_LIMIT)
		|| (port_need && done_cnt[FETCH_I.space] >= EXT_LIMIT)
		|| (port_need && port_busy[fetch_port]));

	assign fetch_go = FETCH_I.req && fs_reg == FS_IDLE && !held_reg
		&& !dec_hold && !pwait;

	// -------------------------------------------------------------
	// Program fetch completion
	// -------------------------------------------------------------
	assign fetch_done = (fetch_go && !(port_need
			&& (bank_cross || !port_rdy[fetch_port])))
		|| (fs_reg == FS_BUSY && port_rdy[fport_reg]);
	assign deliver = fetch_done || held_reg;

	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			fs_reg    <= FS_IDLE;
			fport_reg <= 1'b0;
		end else begin
			unique case (fs_reg)
				FS_IDLE: begin
					if (fetch_go && port_need) begin
						fport_reg <= fetch_port;
						if (bank_cross) begin
							fs_reg <= FS_BANK;
						end else if (!port_rdy[fetch_port]) begin
							fs_reg <= FS_BUSY;
						end
					end
				end
				FS_BANK: begin
					fs_reg <= FS_BUSY;
				end
				FS_BUSY: begin
					if (port_rdy[fport_reg]) begin
						fs_reg <= FS_IDLE;
					end
				end
				default: begin
					fs_reg <= FS_IDLE;
				end
			endcase
		end
	end

	// A word that arrives while decode is held waits in fetch.
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			held_reg <= 1'b0;
		end else begin
			held_reg <= deliver && dec_hold;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			last_addr_reg  <= '0;
			last_valid_reg <= 1'b0;
			pri_addr_reg   <= '0;
			pri_valid_reg  <= 1'b0;
		end else if (fetch_go) begin
			last_addr_reg  <= FETCH_I.addr;
			last_valid_reg <= 1'b1;
			if (port_need && !fetch_port) begin
				pri_addr_reg  <= FETCH_I.addr;
				pri_valid_reg <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------
	// DMA, lowest priority
	// -------------------------------------------------------------
	logic dma_ext;
	logic dma_port;
	logic dma_go;
	logic fetch_here;

	assign dma_ext  = DMA_I.space == MEM_PRI || DMA_I.space == MEM_EXP;
	assign dma_port = DMA_I.space == MEM_EXP;
	assign fetch_here = fetch_go && FETCH_I.space == DMA_I.space
		&& (port_need || int_need);
	assign dma_go = DMA_I.req && DMA_I.space != MEM_NONE
		&& (dma_ext
		? (!port_busy[dma_port] && done_cnt[DMA_I.space] == 3'h0
			&& !fetch_here)
		: (done_cnt[DMA_I.space] + {2'b00, fetch_here}
			< INT_LIMIT));
	assign dma_start = {dma_go && dma_ext && dma_port,
		dma_go && dma_ext && !dma_port};

	// -------------------------------------------------------------
	// Stage controls and status
	// -------------------------------------------------------------
	dpi_conf_t conf_next;
	dpi_conf_t conf_reg;

	always_comb begin
		STALL_O.exec   = exec_hold;
		STALL_O.read   = rd_hold;
		STALL_O.decode = dec_hold;
		STALL_O.fetch  = !(deliver && !dec_hold);
		BUBBLE_O.exec   = !exec_hold && rd_hold;
		BUBBLE_O.read   = !rd_hold && dec_hold;
		BUBBLE_O.decode = !dec_hold && !deliver;
	end

	assign FETCH_START_O = fetch_go;
	assign FETCH_DONE_O  = fetch_done;
	assign DMA_GRANT_O   = dma_go;

	always_comb begin
		conf_next              = CONF_CLEAR;
		conf_next.reg_hold     = reg_haz && !rd_hold;
		conf_next.prog_wait    = pwait && !dec_hold;
		conf_next.fetch_incomp = fs_reg != FS_IDLE && !fetch_done;
		conf_next.exec_only    = ilock_hold || (rd_defer && !hold_all);
		conf_next.hold_all     = hold_all;
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			conf_reg <= CONF_CLEAR;
		end else begin
			conf_reg <= conf_next;
		end
	end

	assign CONFLICT_O = conf_reg;

endmodule : dpi_interlock

// file: logic/dpi_pkg.sv
// Shared types and constants of the pipeline memory interlock.
// Assumes one processor clock for every user of these types.
package dpi_pkg;

	// -------------------------------------------------------------
	// Address and memory constants
	// -------------------------------------------------------------
	localparam int          ADDR_W      = 24;
	localparam int          N_SPACE     = 6;
	localparam logic [23:0] BND_A_LAST  = 24'h7FFFFF;
	localparam logic [23:0] BND_A_FIRST = 24'h800000;
	localparam logic [23:0] BND_B_LAST  = 24'h809FFF;
	localparam logic [23:0] BND_B_FIRST = 24'h80A000;
	localparam logic [2:0]  INT_LIMIT   = 3'h2;
	localparam logic [2:0]  EXT_LIMIT   = 3'h1;
	localparam logic [2:0]  DATA_LIMIT  = 3'h2;
	localparam logic [2:0]  GRP_NONE    = 3'h0;
	localparam logic [2:0]  GRP_AUX     = 3'h1;
	localparam logic [2:0]  GRP_DPP     = 3'h2;
	localparam logic [2:0]  GRP_STK     = 3'h4;

	// -------------------------------------------------------------
	// Enumerations
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		MEM_NONE = 3'b000,
		MEM_RAM0 = 3'b001,
		MEM_RAM1 = 3'b010,
		MEM_ROM  = 3'b011,
		MEM_PRI  = 3'b100,
		MEM_EXP  = 3'b101
	} dpi_space_t;

	typedef enum logic [2:0] {
		RC_NONE  = 3'b000,
		RC_AUX   = 3'b001,
		RC_IDX0  = 3'b010,
		RC_IDX1  = 3'b011,
		RC_BLK   = 3'b100,
		RC_DPP   = 3'b101,
		RC_STK   = 3'b110,
		RC_OTHER = 3'b111
	} dpi_reg_t;

	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_BANK = 2'b01,
		FS_BUSY = 2'b10
	} dpi_fstate_t;

	// -------------------------------------------------------------
	// Stage descriptors and results
	// -------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		dpi_reg_t   src_a;
		dpi_reg_t   src_b;
		logic [2:0] wr_grp;
		dpi_space_t st0;
		dpi_space_t st1;
		logic       ilock_load;
	} dpi_exe_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] wr_grp;
		dpi_space_t rd0;
		dpi_space_t rd1;
	} dpi_rd_t;

	typedef struct packed {
		logic       valid;
		logic [2:0] use_grp;
		logic       loop_ctr;
	} dpi_dec_t;

	typedef struct packed {
		logic              req;
		dpi_space_t        space;
		logic [ADDR_W-1:0] addr;
		logic              cache_hit;
		logic              after_dly_branch;
	} dpi_fetch_t;

	typedef struct packed {
		logic       req;
		dpi_space_t space;
	} dpi_dma_t;

	typedef struct packed {
		logic fetch;
		logic decode;
		logic read;
		logic exec;
	} dpi_stage_t;

	typedef struct packed {
		logic decode;
		logic read;
		logic exec;
	} dpi_bubble_t;

	typedef struct packed {
		logic reg_hold;
		logic prog_wait;
		logic fetch_incomp;
		logic exec_only;
		logic hold_all;
	} dpi_conf_t;

	localparam dpi_conf_t CONF_CLEAR = '{default: 1'b0};

endpackage : dpi_pkg

// file: testbench/dpi_interlock_sva.sv
// Assertions on the ports of the pipeline interlock.
// Assumes one clock and the active-low reset of the top module.
`timescale 1ns/1ps

module dpi_interlock_sva
	import dpi_pkg::*;
(
	input wire logic              CORE_CLK_I,
	input wire logic              RST_N_I,
	input wire logic              EXT_FLAG_ONE_I,
	input wire dpi_exe_t          EXE_I,
	input wire dpi_rd_t           RD_I,
	input wire dpi_dec_t          DEC_I,
	input wire dpi_fetch_t        FETCH_I,
	input wire dpi_dma_t          DMA_I,
	input wire logic              PRI_RDY_I,
	input wire logic              EXP_RDY_I,
	input wire logic [ADDR_W-1:0] PRI_BANK_MASK_I,
	input wire dpi_stage_t        STALL_O,
	input wire dpi_bubble_t       BUBBLE_O,
	input wire logic              FETCH_START_O,
	input wire logic              FETCH_DONE_O,
	input wire logic              DMA_GRANT_O,
	input wire dpi_conf_t         CONFLICT_O
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	aux_hold_a: assert property (
		EXE_I.valid && EXE_I.src_a == RC_AUX && DEC_I.valid &&
		DEC_I.use_grp[0] && !STALL_O.read |-> STALL_O.decode && BUBBLE_O.read)
		else $error("aux read did not hold decode");
	int_wait_a: assert property (
		RD_I.valid && RD_I.rd0 == MEM_RAM0 && RD_I.rd1 == MEM_RAM0 &&
		!EXE_I.valid && FETCH_I.req && FETCH_I.space == MEM_RAM0 &&
		!FETCH_I.cache_hit
		|-> !FETCH_START_O) else $error("third access to a block");
	ext_wait_a: assert property (
		EXE_I.valid && EXE_I.st0 == MEM_PRI && FETCH_I.req &&
		FETCH_I.space == MEM_PRI && !FETCH_I.cache_hit |-> !FETCH_START_O)
		else $error("fetch beside a data access");
	dual_read_a: assert property (
		EXE_I.valid && !EXE_I.ilock_load && EXE_I.st1 == MEM_NONE &&
		EXE_I.st0 inside {MEM_RAM0, MEM_RAM1, MEM_ROM} && RD_I.valid &&
		RD_I.rd0 inside {MEM_RAM0, MEM_RAM1, MEM_ROM} &&
		RD_I.rd1 inside {MEM_RAM0, MEM_RAM1, MEM_ROM}
		|-> STALL_O.read && !STALL_O.exec && BUBBLE_O.exec)
		else $error("dual read not delayed");
	par_store_a: assert property (
		EXE_I.valid && EXE_I.st0 inside {MEM_RAM0, MEM_RAM1, MEM_ROM} &&
		EXE_I.st1 inside {MEM_RAM0, MEM_RAM1, MEM_ROM} && RD_I.valid &&
		RD_I.rd0 inside {MEM_RAM0, MEM_RAM1, MEM_ROM} |-> STALL_O.read)
		else $error("read after two stores not delayed");
	dma_yield_a: assert property (
		DMA_GRANT_O && DMA_I.space inside {MEM_PRI, MEM_EXP} &&
		!FETCH_I.cache_hit
		|-> !(FETCH_START_O && FETCH_I.space == DMA_I.space))
		else $error("dma shares a port with a fetch");
	busy_hold_a: assert property (
		DMA_GRANT_O && DMA_I.space == MEM_PRI && !PRI_RDY_I ##1
		EXE_I.valid && EXE_I.st0 == MEM_PRI |-> STALL_O == 4'hF)
		else $error("busy port did not hold all stages");
	busy_fetch_a: assert property (
		DMA_GRANT_O && DMA_I.space == MEM_PRI && !PRI_RDY_I ##1
		FETCH_I.req && FETCH_I.space == MEM_PRI && !FETCH_I.cache_hit
		|-> !FETCH_START_O)
		else $error("fetch began on a busy port");
	slow_fetch_a: assert property (
		FETCH_START_O && !FETCH_DONE_O |-> BUBBLE_O.decode)
		else $error("slow fetch gave no decode bubble");
	ilock_a: assert property (
		(EXE_I.valid && EXE_I.ilock_load && EXT_FLAG_ONE_I)[*6]
		|-> STALL_O.exec) else $error("interlocked load not held");
endmodule : dpi_interlock_sva

bind dpi_interlock dpi_interlock_sva dpi_interlock_sva_inst (
	.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
	.EXT_FLAG_ONE_I(EXT_FLAG_ONE_I), .EXE_I(EXE_I), .RD_I(RD_I),
	.DEC_I(DEC_I), .FETCH_I(FETCH_I), .DMA_I(DMA_I),
	.PRI_RDY_I(PRI_RDY_I), .EXP_RDY_I(EXP_RDY_I),
	.PRI_BANK_MASK_I(PRI_BANK_MASK_I), .STALL_O(STALL_O),
	.BUBBLE_O(BUBBLE_O), .FETCH_START_O(FETCH_START_O),
	.FETCH_DONE_O(FETCH_DONE_O), .DMA_GRANT_O(DMA_GRANT_O),
	.CONFLICT_O(CONFLICT_O)
);

// file: testbench/dpi_port_model.sv
// Memory port model: ready stays low for a set number of wait states
// after each access it is handed.
// Assumes start is a one-cycle pulse on the block's clock.
`timescale 1ns/1ps

module dpi_port_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [3:0] waits_i,
	output logic            rdy_o
);
	logic       busy_reg;
	logic [3:0] cnt_reg;

	// Idle ready follows the wait count, so a slow access is already slow
	// in its first cycle; a real port gives no warning either.
	assign rdy_o = busy_reg ? (cnt_reg == 4'h0) : (waits_i == 4'h0);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg <= 1'b0;
			cnt_reg  <= 4'h0;
		end else if (busy_reg) begin
			busy_reg <= (cnt_reg != 4'h0);
			cnt_reg  <= cnt_reg - 4'h1;
		end else if (start_i && waits_i != 4'h0) begin
			busy_reg <= 1'b1;
			cnt_reg  <= waits_i - 4'h1;
		end
	end
endmodule : dpi_port_model

// file: testbench/test_dsp_pipeline_memory_interlock.sv
// Self-checking bench of the pipeline interlock with two port models.
// Assumes the combinational outputs settle within 1 ns of an input change.
`timescale 1ns/1ps

module test_dsp_pipeline_memory_interlock;
	import dpi_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        flag = 1'b0;
	dpi_exe_t    exe = '0;
	dpi_rd_t     rd = '0;
	dpi_dec_t    dec = '0;
	dpi_fetch_t  fet = '0;
	dpi_dma_t    dma = '0;
	logic [3:0]  pri_w = 4'h0;
	logic [3:0]  exp_w = 4'h0;
	logic        pri_rdy;
	logic        exp_rdy;
	dpi_stage_t  stall;
	dpi_bubble_t bub;
	logic        fstart;
	logic        fdone;
	logic        grant;
	dpi_conf_t   conf;
	int          fails = 0;
	int          checks = 0;
	int          n;
	wire pri_go = (fstart && fet.space == MEM_PRI) ||
		(grant && dma.space == MEM_PRI);
	wire exp_go = (fstart && fet.space == MEM_EXP) ||
		(grant && dma.space == MEM_EXP);

	always #10 clk = ~clk;

	dpi_interlock dpi_interlock_inst (
		.CORE_CLK_I(clk), .RST_N_I(rst_n), .EXT_FLAG_ONE_I(flag),
		.EXE_I(exe), .RD_I(rd), .DEC_I(dec), .FETCH_I(fet), .DMA_I(dma),
		.PRI_RDY_I(pri_rdy), .EXP_RDY_I(exp_rdy),
		.PRI_BANK_MASK_I(24'hFF0000), .STALL_O(stall), .BUBBLE_O(bub),
		.FETCH_START_O(fstart), .FETCH_DONE_O(fdone),
		.DMA_GRANT_O(grant), .CONFLICT_O(conf));
	dpi_port_model pri_port_inst (.clk_i(clk), .rst_n_i(rst_n),
		.start_i(pri_go), .waits_i(pri_w), .rdy_o(pri_rdy));
	dpi_port_model exp_port_inst (.clk_i(clk), .rst_n_i(rst_n),
		.start_i(exp_go), .waits_i(exp_w), .rdy_o(exp_rdy));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic idle();
		exe = '0;
		rd = '0;
		dec = '0;
		fet = '0;
		dma = '0;
	endtask : idle

	task automatic wrap_up();
		if (fails == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// Runs one fetch and returns the cycles from its start to its word.
	task automatic f_run(input dpi_space_t sp, input logic [23:0] ad,
		output int cyc);
		@(negedge clk);
		idle();
		fet.req = 1'b1;
		fet.space = sp;
		fet.addr = ad;
		#1;
		chk(fstart, 1);
		if (fdone !== 1'b1) chk(bub.decode, 1);
		cyc = 0;
		while (fdone !== 1'b1 && cyc < 8) begin
			@(negedge clk);
			#1;
			cyc++;
		end
		chk(fdone, 1);
		@(negedge clk);
		idle();
	endtask : f_run

	task automatic t_reg();
		dpi_reg_t cls [6];
		cls = '{RC_AUX, RC_STK, RC_IDX0, RC_IDX1, RC_BLK, RC_DPP};
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			idle();
			@(negedge clk);
			exe.valid = 1'b1;
			dec.valid = 1'b1;
			exe.src_a = (i < 6) ? cls[i] : RC_NONE;
			exe.src_b = (i == 6) ? RC_AUX : RC_NONE;
			dec.use_grp = (i == 1) ? GRP_STK : (i == 5) ? GRP_DPP
				: (i == 6) ? GRP_NONE : GRP_AUX;
			dec.loop_ctr = (i == 6);
			rd.valid = (i == 7);
			rd.wr_grp = (i == 7) ? GRP_AUX : GRP_NONE;
			#1;
			chk(stall.decode, i < 2 || i > 5);
			chk(bub.read, i < 2 || i > 5);
		end
	endtask : t_reg

	task automatic t_mem();
		@(negedge clk);
		idle();
		rd = '{1'b1, 3'h0, MEM_RAM0, MEM_RAM0};
		fet.req = 1'b1;
		fet.space = MEM_RAM0;
		#1;
		chk(fstart, 0);
		chk(bub.decode, 1);
		@(negedge clk);
		fet.space = MEM_RAM1;
		#1;
		chk(conf.prog_wait, 1);
		chk(fstart, 1);
		@(negedge clk);
		idle();
		exe.valid = 1'b1;
		exe.st0 = MEM_PRI;
		fet = '{1'b1, MEM_PRI, 24'h000040, 1'b0, 1'b0};
		dma = '{1'b1, MEM_PRI};
		#1;
		chk(fstart, 0);
		chk(grant, 0);
		@(negedge clk);
		fet.space = MEM_EXP;
		dma.space = MEM_EXP;
		#1;
		chk(fstart, 1);
		chk(grant, 0);
		@(negedge clk);
		idle();
		repeat (2) @(negedge clk);
	endtask : t_mem

	task automatic t_dma();
		logic [23:0] ad [6];
		ad = '{24'h000200, BND_A_LAST, BND_A_FIRST, BND_B_LAST,
			BND_B_FIRST, 24'h000300};
		pri_w = 4'h8;
		@(negedge clk);
		idle();
		dma = '{1'b1, MEM_PRI};
		#1;
		chk(grant, 1);
		// Cache hits just below each boundary set up the crossing fetch.
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			idle();
			fet = '{1'b1, MEM_PRI, ad[i], i != 0, i == 5};
			exe.valid = (i == 0);
			exe.st0 = (i == 0) ? MEM_PRI : MEM_NONE;
			#1;
			chk(fstart, i == 1 || i == 3);
			if (i == 0) chk(stall, 4'hF);
			if (i == 1) chk(conf.hold_all, 1);
		end
		repeat (2) @(negedge clk);
		pri_w = 4'h0;
		f_run(MEM_PRI, BND_A_FIRST, n);
		chk(n, 0);
	endtask : t_dma

	task automatic t_exo();
		@(negedge clk);
		idle();
		exe.valid = 1'b1;
		exe.st0 = MEM_RAM0;
		rd = '{1'b1, 3'h0, MEM_RAM1, MEM_ROM};
		#1;
		chk(stall.read, 1);
		chk(stall.decode, 1);
		chk(stall.exec, 0);
		chk(bub.exec, 1);
		@(negedge clk);
		exe.st1 = MEM_RAM1;
		rd.rd1 = MEM_NONE;
		#1;
		chk(conf.exec_only, 1);
		chk(stall.read, 1);
		@(negedge clk);
		exe.st1 = MEM_NONE;
		#1;
		chk(stall.read, 0);
		@(negedge clk);
		idle();
		exe.valid = 1'b1;
		exe.ilock_load = 1'b1;
		flag = 1'b1;
		repeat (6) @(negedge clk);
		flag = 1'b0;
		#1;
		chk(stall.exec, 1);
		chk(conf.exec_only, 1);
		repeat (6) @(negedge clk);
		#1;
		chk(stall.exec, 0);
		@(negedge clk);
		idle();
	endtask : t_exo

	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reg();
		t_mem();
		t_dma();
		t_exo();
		exp_w = 4'h1;
		f_run(MEM_EXP, 24'h000100, n);
		chk(n, 1);
		exp_w = 4'h3;
		f_run(MEM_EXP, 24'h000104, n);
		chk(n, 3);
		exp_w = 4'h0;
		f_run(MEM_PRI, 24'h000010, n);
		chk(n, 2);
		f_run(MEM_PRI, 24'h010020, n);
		chk(n, 2);
		f_run(MEM_PRI, 24'h010024, n);
		chk(n, 0);
		wrap_up();
	end

	// The whole sequence needs well under a thousand cycles.
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule : test_dsp_pipeline_memory_interlock
